// ==== design/cmbc_pkg.sv ====
package cmbc_pkg;
    // Register byte offsets on the APB port
    localparam logic [7:0] OFS_PAIR_01 = 8'h00;
    localparam logic [7:0] OFS_PAIR_23 = 8'h04;
    localparam logic [7:0] OFS_PAIR_45 = 8'h08;
    localparam logic [7:0] OFS_PAIR_67 = 8'h0C;
    localparam logic [7:0] OFS_RX_FULL = 8'h10;
    localparam logic [7:0] OFS_RX_OVF = 8'h14;
    localparam logic [7:0] OFS_BUF_BASE = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;

    // Control byte fields, same layout for odd and even buffer
    localparam int CTL_DIR = 7;
    localparam int CTL_ABT = 6;
    localparam int CTL_ARB = 5;
    localparam int CTL_ERR = 4;
    localparam int CTL_REQ = 3;
    localparam int CTL_AUTO_REMOTE_REPLY_EN = 2;
    localparam int CTL_PRI_LSB = 0;

    // Status register fields
    localparam int STAT_TX_BUSY = 0;
    localparam int STAT_TX_VALID = 1;
    localparam int STAT_RX_PEND = 2;
    localparam int STAT_CUR_LSB = 4;

    // Reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [31:0] FULL_RESET = 32'h0000_0000;
    localparam logic [15:0] OVF_RESET = 16'h0000;
    localparam logic [15:0] BASE_RESET = 16'h0000;

    // Buffer geometry
    localparam int N_TX_BUF = 8;
    localparam logic [2:0] LAST_TX_WORD = 3'h6;
    localparam logic [2:0] LAST_RX_WORD = 3'h7;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_STORE
    } cmbc_fsm_t;
endpackage

// ==== design/cmbc_top.sv ====
// Overview of operation
// - Overflow set storing to full buffer 16-31
// - Pair register: odd high, even low byte
// - Direction bit one means transmit buffer
// - Aborted flag set when message aborted
// - Arbitration-lost flag set on lost arbitration
// - Error flag set on bus error
// - Setting send request clears three flags
// - Send request queues; cleared after success
// - Writing zero to set request aborts
// - Remote frame sets request when enabled
// - Two-bit priority, 11 highest, 00 lowest
// - Buffers live in DMA RAM, software placed
// - Word 0: identifier, substitute remote, extended flag
// - Extended flag selects identifier format
// - Extended identifier split over words 1, 2
// - Word 2 bit 9 remote, extended only
// - Word 2 low nibble is length code
// - Data bytes two per word, odd high
// - Word 6 holds bytes 7 and 6
// - Word 7 records matched filter number
// - Full flag set on store, software clears
module cmbc_top #(
    parameter int MEM_AW = 11
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // DMA RAM port, read data one cycle after mem_rd
    output logic [MEM_AW-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    // Frame to protocol engine
    output logic tx_frame_valid,
    output logic tx_ide,
    output logic [10:0] tx_std_id,
    output logic [17:0] tx_ext_id,
    output logic tx_rtr,
    output logic [3:0] tx_dlc,
    output logic [63:0] tx_data,
    output logic tx_abort_req,
    // Transmit outcome pulses
    input wire logic tx_done_ok,
    input wire logic tx_arb_lost,
    input wire logic tx_bus_error,
    input wire logic tx_aborted,
    // Received frame from protocol engine
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [4:0] rx_buf,
    input wire logic [4:0] rx_filter_hit,
    input wire logic rx_ide,
    input wire logic [10:0] rx_std_id,
    input wire logic [17:0] rx_ext_id,
    input wire logic rx_rtr,
    input wire logic [3:0] rx_dlc,
    input wire logic [63:0] rx_data,
    // Matching remote frame seen
    input wire logic rx_remote_hit,
    input wire logic [2:0] rx_remote_buf
);

    typedef struct packed {
        logic [7:0][7:0] ctl;
        logic [7:0] abt_pend;
        logic [31:0] full;
        logic [15:0] ovf;
        logic [MEM_AW-1:0] base;
        cmbc_pkg::cmbc_fsm_t st;
        logic [2:0] idx;
        logic [2:0] rd_idx;
        logic cap_v;
        logic [2:0] cap_idx;
        logic [2:0] cur;
        logic tx_busy;
        logic tx_valid;
        logic tx_abort;
        logic tx_ide;
        logic tx_srr;
        logic tx_rtrx;
        logic tx_rtr;
        logic [10:0] tx_sid;
        logic [17:0] tx_eid;
        logic [3:0] tx_dlc;
        logic [63:0] tx_data;
        logic rx_pend;
        logic rx_ready;
        logic [4:0] r_buf;
        logic [4:0] r_filt;
        logic r_ide;
        logic r_rtr;
        logic [10:0] r_sid;
        logic [17:0] r_eid;
        logic [3:0] r_dlc;
        logic [63:0] r_data;
        logic [MEM_AW-1:0] mem_addr;
        logic mem_rd;
        logic mem_wr;
        logic [15:0] mem_wdata;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cmbc_state_t;

    cmbc_state_t q;
    cmbc_state_t d;
    logic wr;
    logic [31:0] wm;
    logic [31:0] wv;
    logic [7:0] wb;
    logic [7:0] ob;
    logic [2:0] b;
    logic found;
    logic [2:0] sel;
    logic [1:0] best;

    // Byte lanes that the current write touches
    assign wm = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wv = (pwdata & wm) | (32'(q.base) & ~wm);

    always_comb
    begin
        d = q;
        wr = psel & penable & q.pready & pwrite;
        wb = 8'h00;
        ob = 8'h00;
        b = 3'h0;
        found = 1'h0;
        sel = 3'h0;
        best = 2'h0;
        d.pready = psel & ~penable;
        d.pslverr = 1'h0;
        d.mem_rd = 1'h0;
        d.mem_wr = 1'h0;
        d.cap_v = q.mem_rd;
        d.cap_idx = q.rd_idx;

        // Read data prepared in the setup cycle
        if (psel & ~penable)
        begin
            d.prdata = 32'h0000_0000;
            if (paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0)
            begin
                d.prdata[15:0] = {q.ctl[{paddr[3:2], 1'h1}], q.ctl[{paddr[3:2], 1'h0}]};
            end
            else if (paddr == cmbc_pkg::OFS_RX_FULL)
            begin
                d.prdata = q.full;
            end
            else if (paddr == cmbc_pkg::OFS_RX_OVF)
            begin
                d.prdata[15:0] = q.ovf;
            end
            else if (paddr == cmbc_pkg::OFS_BUF_BASE)
            begin
                d.prdata[MEM_AW-1:0] = q.base;
            end
            else if (paddr == cmbc_pkg::OFS_STATUS)
            begin
                d.prdata[cmbc_pkg::STAT_TX_BUSY] = q.tx_busy;
                d.prdata[cmbc_pkg::STAT_TX_VALID] = q.tx_valid;
                d.prdata[cmbc_pkg::STAT_RX_PEND] = q.rx_pend;
                d.prdata[cmbc_pkg::STAT_CUR_LSB +: 3] = q.cur;
            end
            else
            begin
                d.pslverr = 1'h1;
            end
        end

        for (int i = 0; i < cmbc_pkg::N_TX_BUF; i++)
        begin
            if (q.abt_pend[i] && !(q.tx_busy && q.cur == 3'(i)))
            begin
                d.ctl[i][cmbc_pkg::CTL_REQ] = 1'h0;
                d.ctl[i][cmbc_pkg::CTL_ABT] = 1'h1;
                d.abt_pend[i] = 1'h0;
            end
        end

        // Software writes, taken at the access edge
        if (wr && paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0)
        begin
            for (int l = 0; l < 2; l++)
            begin
                b = {paddr[3:2], 1'(l)};
                wb = pwdata[8*l +: 8];
                ob = q.ctl[b];
                if (pstrb[l])
                begin
                    d.ctl[b][cmbc_pkg::CTL_DIR] = wb[cmbc_pkg::CTL_DIR];
                    d.ctl[b][cmbc_pkg::CTL_AUTO_REMOTE_REPLY_EN] = wb[cmbc_pkg::CTL_AUTO_REMOTE_REPLY_EN];
                    d.ctl[b][cmbc_pkg::CTL_PRI_LSB +: 2] = wb[cmbc_pkg::CTL_PRI_LSB +: 2];
                    if (wb[cmbc_pkg::CTL_REQ] & ~ob[cmbc_pkg::CTL_REQ])
                    begin
                        d.ctl[b][cmbc_pkg::CTL_REQ] = 1'h1;
                        d.ctl[b][cmbc_pkg::CTL_ABT] = 1'h0;
                        d.ctl[b][cmbc_pkg::CTL_ARB] = 1'h0;
                        d.ctl[b][cmbc_pkg::CTL_ERR] = 1'h0;
                        d.abt_pend[b] = 1'h0;
                    end
                    else if (~wb[cmbc_pkg::CTL_REQ] & ob[cmbc_pkg::CTL_REQ])
                    begin
                        d.abt_pend[b] = 1'h1;
                    end
                end
            end
        end
        else if (wr && paddr == cmbc_pkg::OFS_RX_FULL)
        begin
            d.full = q.full & (pwdata | ~wm);
        end
        else if (wr && paddr == cmbc_pkg::OFS_RX_OVF)
        begin
            d.ovf = q.ovf & (pwdata[15:0] | ~wm[15:0]);
        end
        else if (wr && paddr == cmbc_pkg::OFS_BUF_BASE)
        begin
            d.base = wv[MEM_AW-1:0];
        end

        if (rx_remote_hit && q.ctl[rx_remote_buf][cmbc_pkg::CTL_DIR]
            && q.ctl[rx_remote_buf][cmbc_pkg::CTL_AUTO_REMOTE_REPLY_EN])
        begin
            d.ctl[rx_remote_buf][cmbc_pkg::CTL_REQ] = 1'h1;
            d.ctl[rx_remote_buf][cmbc_pkg::CTL_ABT] = 1'h0;
            d.ctl[rx_remote_buf][cmbc_pkg::CTL_ARB] = 1'h0;
            d.ctl[rx_remote_buf][cmbc_pkg::CTL_ERR] = 1'h0;
            d.abt_pend[rx_remote_buf] = 1'h0;
        end

        // Outcome of the frame in flight
        if (q.tx_valid && (tx_done_ok | tx_aborted | tx_arb_lost | tx_bus_error))
        begin
            d.tx_busy = 1'h0;
            d.tx_valid = 1'h0;
            if (tx_done_ok)
            begin
                d.ctl[q.cur][cmbc_pkg::CTL_REQ] = 1'h0;
                d.abt_pend[q.cur] = 1'h0;
            end
            else
            begin
                d.ctl[q.cur][cmbc_pkg::CTL_ARB] = q.ctl[q.cur][cmbc_pkg::CTL_ARB] | tx_arb_lost;
                d.ctl[q.cur][cmbc_pkg::CTL_ERR] = q.ctl[q.cur][cmbc_pkg::CTL_ERR] | tx_bus_error;
                if (tx_aborted | q.abt_pend[q.cur])
                begin
                    d.ctl[q.cur][cmbc_pkg::CTL_REQ] = 1'h0;
                    d.ctl[q.cur][cmbc_pkg::CTL_ABT] = 1'h1;
                    d.abt_pend[q.cur] = 1'h0;
                end
            end
        end
        d.tx_abort = d.tx_valid & d.abt_pend[q.cur];

        for (int i = 0; i < cmbc_pkg::N_TX_BUF; i++)
        begin
            if (q.ctl[i][cmbc_pkg::CTL_DIR] && q.ctl[i][cmbc_pkg::CTL_REQ] && !q.abt_pend[i]
                && (!found || q.ctl[i][cmbc_pkg::CTL_PRI_LSB +: 2] > best))
            begin
                found = 1'h1;
                sel = 3'(i);
                best = q.ctl[i][cmbc_pkg::CTL_PRI_LSB +: 2];
            end
        end

        // Accept a received frame; one held at a time
        if (rx_valid && q.rx_ready)
        begin
            if (q.full[rx_buf])
            begin
                if (rx_buf[4])
                begin
                    d.ovf[rx_buf[3:0]] = 1'h1;
                end
            end
            else if (!(rx_buf[4:3] == 2'h0 && q.ctl[rx_buf[2:0]][cmbc_pkg::CTL_DIR]))
            begin
                d.rx_pend = 1'h1;
                d.rx_ready = 1'h0;
                d.r_buf = rx_buf;
                d.r_filt = rx_filter_hit;
                d.r_ide = rx_ide;
                d.r_rtr = rx_rtr;
                d.r_sid = rx_std_id;
                d.r_eid = rx_ext_id;
                d.r_dlc = rx_dlc;
                d.r_data = rx_data;
            end
        end

        // Capture fetched words, one cycle after the read
        if (q.cap_v)
        begin
            unique case (q.cap_idx)
                3'h0:
                begin
                    d.tx_sid = mem_rdata[12:2];
                    d.tx_srr = mem_rdata[1];
                    d.tx_ide = mem_rdata[0];
                end
                3'h1:
                begin
                    d.tx_eid[17:6] = mem_rdata[11:0];
                end
                3'h2:
                begin
                    d.tx_eid[5:0] = mem_rdata[15:10];
                    d.tx_rtrx = mem_rdata[9];
                    d.tx_dlc = mem_rdata[3:0];
                end
                default:
                begin
                    d.tx_data[{2'(q.cap_idx[1:0] + 2'h1), 4'h0} +: 16] = mem_rdata;
                end
            endcase
            // word 6 ends the data field
            if (q.cap_idx == cmbc_pkg::LAST_TX_WORD)
            begin
                d.tx_rtr = d.tx_ide ? d.tx_rtrx : d.tx_srr;
                d.tx_valid = 1'h1;
                d.st = cmbc_pkg::ST_IDLE;
            end
        end

        // Sequencer for DMA RAM traffic; storing beats fetching
        unique case (q.st)
            cmbc_pkg::ST_IDLE:
            begin
                d.idx = 3'h0;
                if (q.rx_pend)
                begin
                    d.st = cmbc_pkg::ST_STORE;
                end
                else if (!q.tx_busy && found)
                begin
                    d.st = cmbc_pkg::ST_FETCH;
                    d.cur = sel;
                    d.tx_busy = 1'h1;
                end
            end
            cmbc_pkg::ST_FETCH:
            begin
                if (q.idx <= cmbc_pkg::LAST_TX_WORD)
                begin
                    d.mem_rd = 1'h1;
                    d.rd_idx = q.idx;
                    d.mem_addr = q.base + MEM_AW'({2'h0, q.cur, q.idx});
                    d.idx = 3'(q.idx + 3'h1);
                end
            end
            cmbc_pkg::ST_STORE:
            begin
                d.mem_wr = 1'h1;
                d.mem_addr = q.base + MEM_AW'({q.r_buf, q.idx});
                d.idx = 3'(q.idx + 3'h1);
                unique case (q.idx)
                    // word 0 with unused bits zero
                    3'h0: d.mem_wdata = {3'h0, q.r_sid, q.r_ide | q.r_rtr, q.r_ide};
                    3'h1: d.mem_wdata = {4'h0, q.r_eid[17:6]};
                    3'h2: d.mem_wdata = {q.r_eid[5:0], q.r_ide & q.r_rtr, 5'h00, q.r_dlc};
                    3'h7: d.mem_wdata = {3'h0, q.r_filt, 8'h00};
                    default: d.mem_wdata = q.r_data[{2'(q.idx[1:0] + 2'h1), 4'h0} +: 16];
                endcase
                if (q.idx == cmbc_pkg::LAST_RX_WORD)
                begin
                    d.full[q.r_buf] = 1'h1;
                    d.rx_pend = 1'h0;
                    d.rx_ready = 1'h1;
                    d.st = cmbc_pkg::ST_IDLE;
                end
            end
            default:
            begin
                d.st = cmbc_pkg::ST_IDLE;
            end
        endcase
    end

    // State register; everything else is zero at reset
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            q <= '0;
            q.ctl <= {cmbc_pkg::N_TX_BUF{cmbc_pkg::CTL_RESET}};
            q.full <= cmbc_pkg::FULL_RESET;
            q.ovf <= cmbc_pkg::OVF_RESET;
            q.base <= cmbc_pkg::BASE_RESET[MEM_AW-1:0];
            q.st <= cmbc_pkg::ST_IDLE;
            q.rx_ready <= 1'h1;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign mem_addr = q.mem_addr;
    assign mem_rd = q.mem_rd;
    assign mem_wr = q.mem_wr;
    assign mem_wdata = q.mem_wdata;
    assign tx_frame_valid = q.tx_valid;
    assign tx_ide = q.tx_ide;
    assign tx_std_id = q.tx_sid;
    assign tx_ext_id = q.tx_eid;
    assign tx_rtr = q.tx_rtr;
    assign tx_dlc = q.tx_dlc;
    assign tx_data = q.tx_data;
    assign tx_abort_req = q.tx_abort;
    assign rx_ready = q.rx_ready;

endmodule

// ==== verification/cmbc_top_asserts.sv ====
module cmbc_top_asserts #(
    parameter int MEM_AW = 11
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // RAM port
    input wire logic [MEM_AW-1:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    // Engine side
    input wire logic tx_frame_valid,
    input wire logic tx_abort_req,
    input wire logic [10:0] tx_std_id,
    input wire logic [63:0] tx_data,
    input wire logic tx_done_ok,
    input wire logic tx_arb_lost,
    input wire logic tx_bus_error,
    input wire logic tx_aborted,
    input wire logic rx_valid,
    input wire logic rx_ready
);
    logic outc;

    // Any outcome pulse from the engine
    assign outc = tx_done_ok || tx_arb_lost || tx_bus_error || tx_aborted;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_take;
        rx_valid && rx_ready;
    endsequence
    sequence s_wr2;
        mem_wr ##1 mem_wr;
    endsequence

    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_one_beat: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_slverr_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_frame_holds: assert property (tx_frame_valid && !outc |=> tx_frame_valid)
        else $error("frame dropped without outcome");
    a_frame_ends: assert property (tx_frame_valid && outc |=> !tx_frame_valid)
        else $error("frame kept after outcome");
    a_fields_hold: assert property (tx_frame_valid ##1 tx_frame_valid |->
        $stable(tx_std_id) && $stable(tx_data))
        else $error("frame fields moved");
    a_fetch_first: assert property ($rose(tx_frame_valid) |->
        $past(mem_rd, 2) && !$past(mem_rd))
        else $error("frame not fetched before offer");
    a_abort_in_flight: assert property (tx_abort_req |-> tx_frame_valid)
        else $error("abort with no frame");
    a_store_busy: assert property ($rose(mem_wr) |-> !rx_ready [*7] ##1 rx_ready)
        else $error("ready during store");
    a_store_ends: assert property (s_take |-> ##[2:12] rx_ready)
        else $error("store never finished");
    a_store_burst: assert property ($rose(mem_wr) |-> mem_wr [*8] ##1 !mem_wr)
        else $error("store not eight words");
    a_store_step: assert property (s_wr2 |-> mem_addr == $past(mem_addr) + 1'b1)
        else $error("store address not stepping");
endmodule

// ==== verification/cmbc_bus_model.sv ====
module cmbc_bus_model #(
    parameter int AW = 11,
    parameter int LAT = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // RAM port
    input wire logic [AW-1:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    // Engine side
    input wire logic frame_valid,
    input wire logic abort_req,
    input wire logic [1:0] kind,
    output logic done_ok,
    output logic arb_lost,
    output logic bus_error,
    output logic aborted
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:2**AW-1];
    int cnt = 0;

    // Quiet outputs at time zero
    initial {done_ok, arb_lost, bus_error, aborted, rdata} = 20'h0;

    // buffers in shared RAM
    // Idle read data flips so a stale word is never taken for fresh
    always @(posedge clk)
    begin
        rdata <= rd ? mem[addr] : ~rdata;
        if (wr)
            mem[addr] <= wdata;
    end

    // abort answered by aborted
    // One outcome per offer, LAT+1 cycles after it rises; kind picks which
    always @(posedge clk)
    begin
        {done_ok, arb_lost, bus_error, aborted} <= 4'h0;
        cnt <= (rst || !frame_valid) ? 0 : cnt + 1;
        if (!rst && frame_valid && cnt == LAT)
        begin
            done_ok <= !abort_req && kind == 2'h0;
            arb_lost <= !abort_req && kind == 2'h1;
            bus_error <= !abort_req && kind == 2'h2;
            aborted <= abort_req || kind == 2'h3;
        end
    end
endmodule

// ==== verification/tb.sv ====
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic [10:0] mem_addr, tx_std_id, rx_std_id = 11'h000;
    logic mem_rd, mem_wr, tx_frame_valid, tx_ide, tx_rtr, tx_abort_req, re;
    logic [15:0] mem_wdata, mem_rdata, s = 16'h0013;
    logic [17:0] tx_ext_id, rx_ext_id = 18'h0;
    logic [3:0] tx_dlc, rx_dlc = 4'h0;
    logic [63:0] tx_data, rx_data = 64'h0, d;
    logic tx_done_ok, tx_arb_lost, tx_bus_error, tx_aborted, rx_ready;
    logic rx_valid = 0, rx_ide = 1, rx_rtr = 0, rx_remote_hit = 0;
    logic [4:0] rx_buf = 5'h10, rx_filter_hit = 5'h00;
    logic [2:0] rx_remote_buf = 3'h0;
    logic [1:0] kind = 2'h0;
    logic [15:0] ew [8];
    logic [10:0] e_sid [8];
    logic [17:0] e_eid [8];
    logic e_ide [8], e_rtr [8];
    logic [3:0] e_dlc [8];
    logic [63:0] e_dat [8];
    int fails = 0, cmp_count = 0;

    cmbc_top u_dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hF), .prdata, .pready, .pslverr, .mem_addr, .mem_rd, .mem_wr,
        .mem_wdata, .mem_rdata, .tx_frame_valid, .tx_ide, .tx_std_id, .tx_ext_id,
        .tx_rtr, .tx_dlc, .tx_data, .tx_abort_req, .tx_done_ok, .tx_arb_lost,
        .tx_bus_error, .tx_aborted, .rx_valid, .rx_ready, .rx_buf, .rx_filter_hit,
        .rx_ide, .rx_std_id, .rx_ext_id, .rx_rtr, .rx_dlc, .rx_data, .rx_remote_hit,
        .rx_remote_buf);
    cmbc_bus_model u_bus (.clk(sys_clk), .rst, .addr(mem_addr), .rd(mem_rd),
        .wr(mem_wr), .wdata(mem_wdata), .rdata(mem_rdata), .frame_valid(tx_frame_valid),
        .abort_req(tx_abort_req), .kind, .done_ok(tx_done_ok), .arb_lost(tx_arb_lost),
        .bus_error(tx_bus_error), .aborted(tx_aborted));

    // Clock and a two cycle reset
    initial forever #12.5 sys_clk = ~sys_clk;
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
    end

    function automatic logic [15:0] lf();
        s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
        return s;
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One APB transfer; request held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // software frame layout
    // Word 2 remote bit inverted on standard frames, where it must be ignored
    task automatic put(input int n);
        d = {lf(), lf(), lf(), lf()};
        {e_eid[n], e_sid[n], e_dlc[n], e_rtr[n], e_ide[n]} = d[34:0];
        e_dat[n] = {lf(), lf(), lf(), lf()};
        u_bus.mem[n*8] = {3'h0, e_sid[n], e_ide[n] | e_rtr[n], e_ide[n]};
        u_bus.mem[n*8+1] = {4'h0, e_eid[n][17:6]};
        u_bus.mem[n*8+2] = {e_eid[n][5:0], e_ide[n] ? e_rtr[n] : ~e_rtr[n], 5'h00, e_dlc[n]};
        for (int k = 0; k < 4; k++)
            u_bus.mem[n*8+3+k] = e_dat[n][16*k+:16];
    endtask

    task automatic wv(input int n);
        for (int i = 0; i < 60 && tx_frame_valid !== 1'b1; i++) @(posedge sys_clk);
        `CHK("tx ide", e_ide[n], tx_ide)
        `CHK("tx sid", e_sid[n], tx_std_id)
        `CHK("tx rtr", e_rtr[n], tx_rtr)
        `CHK("tx dlc", e_dlc[n], tx_dlc)
        `CHK("tx data", e_dat[n], tx_data)
        if (e_ide[n])
            `CHK("tx eid", e_eid[n], tx_ext_id)
    endtask

    task automatic wf(input int n);
        wv(n);
        for (int i = 0; i < 60 && tx_frame_valid !== 1'b0; i++) @(posedge sys_clk);
    endtask

    // Random received frame, handshake then wait for the store to end
    task automatic rxs();
        d = {lf(), lf(), lf(), lf()};
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        {rx_ext_id, rx_std_id, rx_dlc, rx_rtr, rx_filter_hit} <= d[38:0];
        rx_data <= {lf(), lf(), lf(), lf()};
        do @(posedge sys_clk); while (rx_ready !== 1'b1);
        rx_valid <= 1'b0;
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 30 && rx_ready !== 1'b1; i++) @(posedge sys_clk);
        // Last word lands in the RAM model at this same edge
        @(posedge sys_clk);
    endtask

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        end_of_test();
    end

    initial
    begin
        repeat (4) @(posedge sys_clk);
        for (int a = 0; a < 7; a++)
        begin
            apb(1'b0, 8'(a * 4), 32'h0);
            `CHK("reset value", 32'h0, rv)
        end
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 1'b1, re)
        put(0);
        put(1);
        put(2);
        // Odd buffer priority 11 beats even buffer priority 10
        kind <= 2'h1;
        apb(1'b1, 8'h00, 32'h0000_8B8A);
        wf(1);
        kind <= 2'h2;
        apb(1'b0, 8'h00, 32'h0);
        `CHK("arb lost", 8'hAB, rv[15:8])
        wf(1);
        kind <= 2'h0;
        apb(1'b0, 8'h00, 32'h0);
        `CHK("bus error", 8'hBB, rv[15:8])
        wf(1);
        apb(1'b0, 8'h00, 32'h0);
        `CHK("sent ok", 8'hB3, rv[15:8])
        wf(0);
        apb(1'b0, 8'h00, 32'h0);
        `CHK("even sent", 8'h82, rv[7:0])
        // Re-request with read-only bits written high
        apb(1'b1, 8'h00, 32'h0000_FB82);
        apb(1'b0, 8'h00, 32'h0);
        `CHK("flags cleared", 8'h8B, rv[15:8])
        wv(1);
        apb(1'b1, 8'h00, 32'h0000_8382);
        wf(1);
        apb(1'b0, 8'h00, 32'h0);
        `CHK("aborted", 8'hC3, rv[15:8])
        // Remote frame with auto reply off, then on
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, 8'h04, i ? 32'h85 : 32'h81);
            @(posedge sys_clk);
            rx_remote_hit <= 1'b1;
            rx_remote_buf <= 3'h2;
            @(posedge sys_clk);
            rx_remote_hit <= 1'b0;
            if (i)
                wf(2);
            apb(1'b0, 8'h04, 32'h0);
            `CHK("remote reply", i ? 8'h85 : 8'h81, rv[7:0])
        end
        rxs();
        ew = '{{3'h0, rx_std_id, 2'h3}, {4'h0, rx_ext_id[17:6]},
            {rx_ext_id[5:0], rx_rtr, 5'h00, rx_dlc}, rx_data[15:0], rx_data[31:16],
            rx_data[47:32], rx_data[63:48], {3'h0, rx_filter_hit, 8'h00}};
        for (int r = 0; r < 2; r++)
        begin
            for (int k = 0; k < 8; k++)
                `CHK("rx word", ew[k], u_bus.mem[128+k])
            apb(1'b0, 8'h10, 32'h0);
            `CHK("full flag", 1'b1, rv[16])
            if (r == 0)
                rxs();
        end
        // Overflow clears only on a written zero
        for (int i = 0; i < 3; i++)
        begin
            if (i)
                apb(1'b1, 8'h14, i == 1 ? 32'hFFFF : 32'h0);
            apb(1'b0, 8'h14, 32'h0);
            `CHK("overflow", i == 2 ? 32'h0 : 32'h1, rv)
        end
        end_of_test();
    end
endmodule

bind cmbc_top cmbc_top_asserts #(.MEM_AW(MEM_AW)) u_chk (.sys_clk, .rst, .psel, .penable,
    .pready, .pslverr, .mem_addr, .mem_rd, .mem_wr, .tx_frame_valid, .tx_abort_req,
    .tx_std_id, .tx_data, .tx_done_ok, .tx_arb_lost, .tx_bus_error, .tx_aborted,
    .rx_valid, .rx_ready);
